// File: hdl/fpa_pkg.sv
// constants for the fault pin aggregator: fault bit layout, pin maps, temperature trip points
// assumes fault sources arrive as synchronous levels and clears as one-cycle write-one pulses
// Operation
// R1: the alarm is an active-low open-drain output so several devices can share one pull-up.
// R2: the alarm is released while no enabled fault is present and pulled low while any enabled, unmasked fault is;
// the alarm follows the enabled result bits instead and stays low while one is held.
// R3: every readback carries a mirror bit that reads 1 whenever the alarm output is active.
// R4: calibration-not-refreshed, reset-detected and capacitor-detection flags never drive the alarm and have no mask.
// R5: three-wire link, background CRC and calibration memory CRC errors always drive the alarm.
// R6: the listed digital faults drive the alarm unless their own mask bit is set.
// R7: the serial clock count error has no mask and is kept off the alarm only by the quiet enable bit.
// R8: the listed analog faults drive the alarm unless their own mask bit is set.
// R9: converter power and the four comparator errors always drive the alarm.
// R10: one mask bit per maskable source, a set bit keeps that source off the alarm.
// R11: masking touches only the alarm and mirror, the result bit still records the fault.
// R12: digital, analog and watchdog summary bits let the host find the category of an alarm.
// R13: result bits are sticky, writing 1 updates them to the present fault level; the calibration-not-refreshed bit follows its live level instead.
// R14: a die temperature above the trip point sets its analog result bit and drives the alarm.
package fpa_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int DIG_W = 16;
    localparam int ANA_W = 12;
    localparam int TEMP_W = 8;
    localparam int TRIP_W = 2;

    // ************************************************************
    // digital result bit positions
    // ************************************************************
    localparam int D_OSC_STOP = 0;
    localparam int D_CAL_UNREFRESHED = 1;
    localparam int D_RESET_SEEN = 2;
    localparam int D_THREE_WIRE = 3;
    localparam int D_WDT_LATE = 4;
    localparam int D_WDT_EARLY = 5;
    localparam int D_BG_CRC = 6;
    localparam int D_DAC_LATCH = 7;
    localparam int D_DUAL_CALC = 8;
    localparam int D_INV_DAC = 9;
    localparam int D_CALMEM_CRC = 10;
    localparam int D_BAD_ACCESS = 11;
    localparam int D_LOCKED_WRITE = 12;
    localparam int D_SCLK_COUNT = 13;
    localparam int D_SLIP_BIT = 14;
    localparam int D_SERIAL_CRC = 15;

    // ************************************************************
    // analog result bit positions
    // ************************************************************
    localparam int A_OVERVOLT = 0;
    localparam int A_CONV_SHORT = 1;
    localparam int A_CONV_POWER = 2;
    localparam int A_CAP_DETECT = 3;
    localparam int A_IOUT_OPEN = 4;
    localparam int A_VOUT_SHORT = 5;
    localparam int A_CONV_TEMP = 6;
    localparam int A_MAIN_TEMP = 7;
    localparam int A_REF_OUTPUT = 8;
    localparam int A_REF_INPUT = 9;
    localparam int A_INT_SUPPLY = 10;
    localparam int A_LDO_CMP = 11;

    // ************************************************************
    // pin maps
    // ************************************************************
    localparam logic [DIG_W-1:0] DIG_MASKABLE = 16'hdbb1;
    localparam logic [DIG_W-1:0] DIG_ALWAYS = 16'h0448;
    localparam logic [DIG_W-1:0] DIG_QUIETABLE = 16'h2000;
    localparam logic [DIG_W-1:0] DIG_AUTO_CLEAR = 16'h0002;
    localparam logic [ANA_W-1:0] ANA_MASKABLE = 12'h0f3;
    localparam logic [ANA_W-1:0] ANA_ALWAYS = 12'hf04;
    localparam logic [DIG_W-1:0] DIG_WATCHDOG = 16'h0030;

    // ************************************************************
    // reset values and temperature trip points in degrees C
    // ************************************************************
    localparam logic [DIG_W-1:0] DIG_RESET = 16'h0000;
    localparam logic [ANA_W-1:0] ANA_RESET = 12'h000;
    localparam logic [TEMP_W-1:0] TRIP_0 = 8'h8e;
    localparam logic [TEMP_W-1:0] TRIP_1 = 8'h7f;
    localparam logic [TEMP_W-1:0] TRIP_2 = 8'h70;
    localparam logic [TEMP_W-1:0] TRIP_3 = 8'h61;

endpackage : fpa_pkg

// File: hdl/fpa_top.sv
// fault pin aggregator: sticky diagnostic results, alarm mapping, open-drain alarm pin
// assumes all inputs are synchronous to clk_i and the pad resolves the shared pulled-up line
`timescale 1ns/10ps
module fpa_top
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [fpa_pkg::DIG_W-1:0] dig_fault_i,
    input wire logic [fpa_pkg::ANA_W-1:0] ana_fault_i,
    input wire logic [fpa_pkg::TEMP_W-1:0] main_temp_i,
    input wire logic [fpa_pkg::TEMP_W-1:0] conv_temp_i,
    input wire logic [fpa_pkg::TRIP_W-1:0] trip_sel_i,
    input wire logic [fpa_pkg::DIG_W-1:0] dig_mask_i,
    input wire logic [fpa_pkg::ANA_W-1:0] ana_mask_i,
    input wire logic serial_diag_quiet_enable_i,
    input wire logic [fpa_pkg::DIG_W-1:0] dig_update_i,
    input wire logic [fpa_pkg::ANA_W-1:0] ana_update_i,
    output logic [fpa_pkg::DIG_W-1:0] dig_result_o,
    output logic [fpa_pkg::ANA_W-1:0] ana_result_o,
    output logic digital_diag_summary_o,
    output logic analog_diag_summary_o,
    output logic watchdog_summary_o,
    output logic fault_pin_status_o,
    output logic alarm_out_o,
    output logic alarm_oe_n_o
);

    // ************************************************************
    // state
    // ************************************************************
    logic [fpa_pkg::DIG_W-1:0] dig_res_reg;
    logic [fpa_pkg::DIG_W-1:0] dig_res_next;
    logic [fpa_pkg::ANA_W-1:0] ana_res_reg;
    logic [fpa_pkg::ANA_W-1:0] ana_res_next;
    logic alarm_reg;
    logic alarm_next;
    logic dig_sum_reg;
    logic ana_sum_reg;
    logic wdt_sum_reg;

    // ************************************************************
    // temperature comparators
    // ************************************************************
    logic [fpa_pkg::TEMP_W-1:0] trip_level;
    logic main_hot;
    logic conv_hot;
    logic [fpa_pkg::ANA_W-1:0] temp_set;
    logic [fpa_pkg::ANA_W-1:0] ana_raw;
    localparam logic [fpa_pkg::ANA_W-1:0] ANA_ONE = 12'h001;

    // trip point picked by the two select bits
    assign trip_level = (trip_sel_i == 2'h0) ? fpa_pkg::TRIP_0 :
                        (trip_sel_i == 2'h1) ? fpa_pkg::TRIP_1 :
                        (trip_sel_i == 2'h2) ? fpa_pkg::TRIP_2 : fpa_pkg::TRIP_3;
    // strictly above the trip point counts as hot
    assign main_hot = main_temp_i > trip_level; // R14
    assign conv_hot = conv_temp_i > trip_level; // R14
    // comparator outputs folded onto the two temperature bits
    assign temp_set = (ANA_ONE << fpa_pkg::A_MAIN_TEMP) & {fpa_pkg::ANA_W{main_hot}}
                    | (ANA_ONE << fpa_pkg::A_CONV_TEMP) & {fpa_pkg::ANA_W{conv_hot}};
    assign ana_raw = ana_fault_i | temp_set; // R14

    // ************************************************************
    // sticky result update
    // ************************************************************
    // a write of 1 reloads the bit with the live level; a live fault always sets
    assign dig_res_next = (dig_fault_i | (dig_res_reg & ~dig_update_i)) & ~fpa_pkg::DIG_AUTO_CLEAR
                        | (dig_fault_i & fpa_pkg::DIG_AUTO_CLEAR); // R13 R4
    assign ana_res_next = ana_raw | (ana_res_reg & ~ana_update_i); // R13 R14

    // ************************************************************
    // alarm mapping
    // ************************************************************
    logic [fpa_pkg::DIG_W-1:0] dig_enabled;
    logic [fpa_pkg::ANA_W-1:0] ana_enabled;
    logic [fpa_pkg::DIG_W-1:0] dig_quiet_map;

    // quiet enable drops the serial clock count error from the pin only
    assign dig_quiet_map = serial_diag_quiet_enable_i ? {fpa_pkg::DIG_W{1'b0}} : fpa_pkg::DIG_QUIETABLE; // R7
    // mask touches only maskable positions; unmapped flags never reach the pin
    assign dig_enabled = (fpa_pkg::DIG_MASKABLE & ~dig_mask_i) // R6 R10
                       | fpa_pkg::DIG_ALWAYS // R5
                       | dig_quiet_map; // R4 R7
    assign ana_enabled = (fpa_pkg::ANA_MASKABLE & ~ana_mask_i) // R8 R10
                       | fpa_pkg::ANA_ALWAYS; // R9 R4
    // alarm follows the next result values so pin and results move together
    assign alarm_next = |(dig_res_next & dig_enabled) | |(ana_res_next & ana_enabled); // R2 R11

    // ************************************************************
    // registers
    // ************************************************************
    // results, alarm and summaries, all frozen while ce_i is low
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dig_res_reg <= fpa_pkg::DIG_RESET;
            ana_res_reg <= fpa_pkg::ANA_RESET;
            alarm_reg <= 1'b0;
            dig_sum_reg <= 1'b0;
            ana_sum_reg <= 1'b0;
            wdt_sum_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            dig_res_reg <= dig_res_next; // R13 R11
            ana_res_reg <= ana_res_next; // R13 R11
            alarm_reg <= alarm_next; // R2
            dig_sum_reg <= |dig_res_next; // R12
            ana_sum_reg <= |ana_res_next; // R12
            wdt_sum_reg <= |(dig_res_next & fpa_pkg::DIG_WATCHDOG); // R12
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // open-drain pad: the data is always low, only the enable moves
    assign alarm_out_o = 1'b0; // R1
    assign alarm_oe_n_o = ~alarm_reg; // R1 R2
    // mirror reads 1 while the pin is pulled low
    assign fault_pin_status_o = alarm_reg; // R3
    assign dig_result_o = dig_res_reg;
    assign ana_result_o = ana_res_reg;
    assign digital_diag_summary_o = dig_sum_reg; // R12
    assign analog_diag_summary_o = ana_sum_reg; // R12
    assign watchdog_summary_o = wdt_sum_reg; // R12

    // ************************************************************
    // checks
    // ************************************************************
    // the pad never drives high
    pad_low_a: assert property (@(posedge clk_i) disable iff (rst_i) alarm_out_o == 1'b0) // R1
        else $error("alarm pad data not low");

    // pin and mirror stay complementary
    mirror_pin_a: assert property (@(posedge clk_i) disable iff (rst_i) fault_pin_status_o == !alarm_oe_n_o) // R3
        else $error("mirror bit disagrees with pin");

    // an always-mapped digital fault pulls the pin on the next edge
    always_dig_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && |(dig_fault_i & fpa_pkg::DIG_ALWAYS)) |=> !alarm_oe_n_o) // R5
        else $error("always-mapped digital fault missed the pin");

    // an always-mapped analog fault pulls the pin on the next edge
    always_ana_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && |(ana_fault_i & fpa_pkg::ANA_ALWAYS)) |=> fault_pin_status_o) // R9
        else $error("always-mapped analog fault missed the pin");

    // unmapped flags alone never activate the pin
    unmapped_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && (dig_res_next & ~fpa_pkg::DIG_AUTO_CLEAR & ~(fpa_pkg::DIG_ALWAYS | fpa_pkg::DIG_MASKABLE
        | fpa_pkg::DIG_QUIETABLE)) == 16'h0000 && ((dig_res_next & ~16'h0006) == 16'h0000)
        && ((ana_res_next & ~(ANA_ONE << fpa_pkg::A_CAP_DETECT)) == 12'h000)) |=> alarm_oe_n_o) // R4
        else $error("unmapped flag drove the pin");

    // an unmasked digital fault pulls the pin
    unmasked_dig_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && |(dig_fault_i & fpa_pkg::DIG_MASKABLE & ~dig_mask_i)) |=> fault_pin_status_o) // R6
        else $error("unmasked digital fault missed the pin");

    // an unmasked analog fault pulls the pin
    unmasked_ana_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && |(ana_fault_i & fpa_pkg::ANA_MASKABLE & ~ana_mask_i)) |=> fault_pin_status_o) // R8
        else $error("unmasked analog fault missed the pin");

    // count error reaches the pin unless quiet enable is set
    sclk_loud_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !serial_diag_quiet_enable_i && dig_fault_i[fpa_pkg::D_SCLK_COUNT]) |=> fault_pin_status_o) // R7
        else $error("count error missed the pin");

    // a masked fault is still recorded
    masked_kept_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && |(dig_fault_i & dig_mask_i)) |=> |(dig_result_o & $past(dig_fault_i) & $past(dig_mask_i))) // R10 R11
        else $error("masked fault not recorded");

    // a recorded fault stays until a write of 1 with the fault gone
    sticky_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && ana_res_reg[fpa_pkg::A_IOUT_OPEN] && !ana_update_i[fpa_pkg::A_IOUT_OPEN])
        |=> ana_result_o[fpa_pkg::A_IOUT_OPEN]) // R13
        else $error("sticky bit lost without update");

    // update with the fault gone clears the bit
    update_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && dig_update_i[fpa_pkg::D_SLIP_BIT] && !dig_fault_i[fpa_pkg::D_SLIP_BIT])
        |=> !dig_result_o[fpa_pkg::D_SLIP_BIT]) // R13
        else $error("update did not reload bit");

    // summaries follow their result groups
    summary_or_a: assert property (@(posedge clk_i) disable iff (rst_i)
        digital_diag_summary_o == |dig_result_o && analog_diag_summary_o == |ana_result_o
        && watchdog_summary_o == |(dig_result_o & fpa_pkg::DIG_WATCHDOG)) // R12
        else $error("summary bits out of step");

    // a hot die sets its bit and the pin when not masked
    hot_die_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && main_temp_i > trip_level) |=> ana_result_o[fpa_pkg::A_MAIN_TEMP]
        && (fault_pin_status_o || $past(ana_mask_i[fpa_pkg::A_MAIN_TEMP]))) // R14
        else $error("overtemperature not flagged");

    // reset empties results and frees the pin
    reset_clear_a: assert property (@(posedge clk_i) // R2
        rst_i
        |=> dig_result_o == fpa_pkg::DIG_RESET && ana_result_o == fpa_pkg::ANA_RESET && alarm_oe_n_o)
        else $error("reset left state behind");

    // a low clock enable freezes results and pin
    freeze_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        !ce_i
        |=> $stable(dig_result_o) && $stable(ana_result_o) && $stable(fault_pin_status_o))
        else $error("state moved while clock enable low");

    // with quiet enable a lone count error leaves the pin free
    quiet_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        (ce_i && serial_diag_quiet_enable_i && dig_res_next == fpa_pkg::DIG_QUIETABLE
        && ana_res_next == fpa_pkg::ANA_RESET) |=> alarm_oe_n_o)
        else $error("quiet enable did not hold the pin");

    // results that are all masked leave the pin free
    masked_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        (ce_i && (dig_res_next & ~(fpa_pkg::DIG_MASKABLE & dig_mask_i)) == fpa_pkg::DIG_RESET
        && (ana_res_next & ~(fpa_pkg::ANA_MASKABLE & ana_mask_i)) == fpa_pkg::ANA_RESET) |=> alarm_oe_n_o)
        else $error("masked fault drove the pin");

    // a hot converter die sets its bit and the pin when not masked
    conv_hot_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
        (ce_i && conv_temp_i > trip_level && !ana_mask_i[fpa_pkg::A_CONV_TEMP])
        |=> ana_result_o[fpa_pkg::A_CONV_TEMP] && fault_pin_status_o)
        else $error("converter overtemperature not flagged");

    // a main die at or below the trip point reloads its bit to 0
    cool_die_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
        (ce_i && main_temp_i <= trip_level && !ana_fault_i[fpa_pkg::A_MAIN_TEMP]
        && ana_update_i[fpa_pkg::A_MAIN_TEMP])
        |=> !ana_result_o[fpa_pkg::A_MAIN_TEMP])
        else $error("cool die left its bit set");

    // an update while the fault stands keeps the bit
    keep_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        (ce_i && dig_update_i[fpa_pkg::D_BG_CRC] && dig_fault_i[fpa_pkg::D_BG_CRC])
        |=> dig_result_o[fpa_pkg::D_BG_CRC])
        else $error("update cleared a standing fault");

    // the refresh flag follows its live level
    cal_follow_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        ce_i
        |=> dig_result_o[fpa_pkg::D_CAL_UNREFRESHED] == $past(dig_fault_i[fpa_pkg::D_CAL_UNREFRESHED]))
        else $error("refresh flag not following its level");

    // a masked analog fault is still recorded
    ana_kept_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        (ce_i && |(ana_fault_i & ana_mask_i))
        |=> |(ana_result_o & $past(ana_fault_i) & $past(ana_mask_i)))
        else $error("masked analog fault not recorded");

    // a recorded digital fault stays without an update
    dig_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        (ce_i && dig_res_reg[fpa_pkg::D_THREE_WIRE] && !dig_update_i[fpa_pkg::D_THREE_WIRE])
        |=> dig_result_o[fpa_pkg::D_THREE_WIRE])
        else $error("digital sticky bit lost");

    // an analog update with the fault gone clears the bit
    ana_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        (ce_i && ana_update_i[fpa_pkg::A_OVERVOLT] && !ana_fault_i[fpa_pkg::A_OVERVOLT])
        |=> !ana_result_o[fpa_pkg::A_OVERVOLT])
        else $error("analog update did not reload bit");

    // a lone reset-detected flag never pulls the pin
    reset_never_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        (ce_i && dig_res_next == (16'h0001 << fpa_pkg::D_RESET_SEEN) && ana_res_next == fpa_pkg::ANA_RESET)
        |=> alarm_oe_n_o)
        else $error("reset flag drove the pin");

    // a lone capacitor flag never pulls the pin
    cap_never_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        (ce_i && dig_res_next == fpa_pkg::DIG_RESET && ana_res_next == (ANA_ONE << fpa_pkg::A_CAP_DETECT))
        |=> alarm_oe_n_o)
        else $error("capacitor flag drove the pin");

    // the pin stands while an always-mapped result is held
    pin_stands_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        (ce_i && |(dig_res_reg & fpa_pkg::DIG_ALWAYS) && dig_update_i == 16'h0000)
        |=> fault_pin_status_o)
        else $error("pin dropped with a fault held");

    // a watchdog fault raises both its summaries
    wdt_sum_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        (ce_i && |(dig_fault_i & fpa_pkg::DIG_WATCHDOG))
        |=> watchdog_summary_o && digital_diag_summary_o)
        else $error("watchdog summary missed");

    // any analog fault raises the analog summary
    ana_sum_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        (ce_i && |ana_fault_i)
        |=> analog_diag_summary_o)
        else $error("analog summary missed");

    // no result at all leaves the pin free
    pin_free_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        (ce_i && dig_res_next == fpa_pkg::DIG_RESET && ana_res_next == fpa_pkg::ANA_RESET)
        |=> alarm_oe_n_o && !fault_pin_status_o)
        else $error("pin active with no result");

endmodule : fpa_top

// File: tb/fpa_host_model.sv
// host side of the shared alarm line: pull-up resistor plus an optional second device on the line
// assumes the alarm pad is split into data and active-low enable, both from the device
`timescale 1ns/10ps
module fpa_host_model
(
    input wire logic alarm_out_i,
    input wire logic alarm_oe_n_i,
    input wire logic other_pull_n_i,
    output logic line_o
);
    // ************************************************************
    // wired line resolution
    // ************************************************************
    // the pull-up holds the line high unless some party pulls it low
    logic dev_level;
    assign dev_level = (alarm_oe_n_i == 1'b0) ? alarm_out_i : 1'b1;
    assign line_o = dev_level & other_pull_n_i;
endmodule : fpa_host_model

// File: tb/fpa_top_bench.sv
// self-checking bench for the fault pin aggregator
// assumes the host model resolves the shared line; inputs change on the falling clock edge
`timescale 1ns/10ps
module fpa_top_bench;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, quiet = 1'b0, other_pull_n = 1'b1;
    logic [15:0] dig_fault = 16'h0000, dig_mask = 16'h0000, dig_update = 16'h0000;
    logic [11:0] ana_fault = 12'h000, ana_mask = 12'h000, ana_update = 12'h000;
    logic [7:0] main_temp = 8'h00, conv_temp = 8'h00;
    logic [1:0] trip_sel = 2'h0;
    logic [15:0] dig_result;
    logic [11:0] ana_result;
    logic dig_sum, ana_sum, wdt_sum, mirror, alarm_out, alarm_oe_n, line;
    logic [15:0] d_msk, d_alw, d_q, a_msk, a_alw;
    logic [7:0] trips [4] = '{fpa_pkg::TRIP_0, fpa_pkg::TRIP_1, fpa_pkg::TRIP_2, fpa_pkg::TRIP_3};
    int mismatches = 0;
    int samples_checked = 0;

    always #5 clk = ~clk;

    fpa_top dut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .dig_fault_i(dig_fault), .ana_fault_i(ana_fault),
        .main_temp_i(main_temp), .conv_temp_i(conv_temp), .trip_sel_i(trip_sel), .dig_mask_i(dig_mask),
        .ana_mask_i(ana_mask), .serial_diag_quiet_enable_i(quiet), .dig_update_i(dig_update),
        .ana_update_i(ana_update), .dig_result_o(dig_result), .ana_result_o(ana_result),
        .digital_diag_summary_o(dig_sum), .analog_diag_summary_o(ana_sum), .watchdog_summary_o(wdt_sum),
        .fault_pin_status_o(mirror), .alarm_out_o(alarm_out), .alarm_oe_n_o(alarm_oe_n));

    fpa_host_model host (.alarm_out_i(alarm_out), .alarm_oe_n_i(alarm_oe_n), .other_pull_n_i(other_pull_n),
        .line_o(line));

    // ************************************************************
    // compare and verdict tasks
    // ************************************************************
    task automatic check_bus(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check_bus

    task automatic check_bit(input string name, input logic exp, input logic got);
        check_bus(name, {15'h0000, exp}, {15'h0000, got});
    endtask : check_bit

    task automatic give_verdict();
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    // every port result against expected results and pin state
    task automatic check_all(input logic [15:0] ed, input logic [15:0] ea, input logic ep);
        check_bus("dig_result", ed, dig_result);
        check_bus("ana_result", ea, {4'h0, ana_result});
        check_bit("dig_summary", |ed, dig_sum);
        check_bit("ana_summary", |ea, ana_sum);
        check_bit("wdt_summary", ed[fpa_pkg::D_WDT_LATE] | ed[fpa_pkg::D_WDT_EARLY], wdt_sum);
        check_bit("mirror", ep, mirror);
        check_bit("pin_enable_n", ~ep, alarm_oe_n);
        check_bit("pin_data", 1'b0, alarm_out);
        check_bit("line", ~ep, line);
    endtask : check_all

    // ************************************************************
    // scenario tasks
    // ************************************************************
    // one source: set, held after it drops, update while present, update after it drops
    task automatic probe(input logic ana, input int i, input logic full);
        logic [15:0] dv;
        logic [11:0] av;
        logic pin;
        dv = ana ? 16'h0000 : 16'h0001 << i;
        av = ana ? 12'h001 << i : 12'h000;
        pin = ana ? (a_alw[i] | (a_msk[i] & ~full)) : (d_alw[i] | ((d_msk[i] | d_q[i]) & ~full));
        dig_mask = {16{full}};
        ana_mask = {12{full}};
        quiet = full;
        dig_fault = dv;
        ana_fault = av;
        @(negedge clk);
        check_all(dv, {4'h0, av}, pin);
        dig_fault = 16'h0000;
        ana_fault = 12'h000;
        @(negedge clk);
        check_all(dv & ~fpa_pkg::DIG_AUTO_CLEAR, {4'h0, av}, pin);
        dig_fault = dv;
        ana_fault = av;
        dig_update = dv;
        ana_update = av;
        @(negedge clk);
        check_all(dv, {4'h0, av}, pin);
        dig_fault = 16'h0000;
        ana_fault = 12'h000;
        @(negedge clk);
        dig_update = 16'h0000;
        ana_update = 12'h000;
        check_all(16'h0000, 16'h0000, 1'b0);
    endtask : probe

    // trip point: equal does not trip, one above trips each die
    task automatic temp_case(input int s);
        logic [15:0] mt, ct;
        mt = 16'h0001 << fpa_pkg::A_MAIN_TEMP;
        ct = 16'h0001 << fpa_pkg::A_CONV_TEMP;
        trip_sel = s[1:0];
        main_temp = trips[s];
        conv_temp = trips[s];
        @(negedge clk);
        check_all(16'h0000, 16'h0000, 1'b0);
        main_temp = trips[s] + 8'h01;
        @(negedge clk);
        check_all(16'h0000, mt, 1'b1);
        main_temp = 8'h00;
        conv_temp = trips[s] + 8'h01;
        @(negedge clk);
        check_all(16'h0000, mt | ct, 1'b1);
        conv_temp = 8'h00;
        ana_update = 12'hfff;
        @(negedge clk);
        ana_update = 12'h000;
        check_all(16'h0000, 16'h0000, 1'b0);
    endtask : temp_case

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial
    begin
        d_msk = 16'h0000;
        d_alw = 16'h0000;
        d_q = 16'h0000;
        a_msk = 16'h0000;
        a_alw = 16'h0000;
        foreach (d_msk[k])
        begin
            d_msk[k] = k inside {fpa_pkg::D_OSC_STOP, fpa_pkg::D_WDT_LATE, fpa_pkg::D_WDT_EARLY,
                fpa_pkg::D_DAC_LATCH, fpa_pkg::D_DUAL_CALC, fpa_pkg::D_INV_DAC, fpa_pkg::D_BAD_ACCESS,
                fpa_pkg::D_LOCKED_WRITE, fpa_pkg::D_SLIP_BIT, fpa_pkg::D_SERIAL_CRC};
            d_alw[k] = k inside {fpa_pkg::D_THREE_WIRE, fpa_pkg::D_BG_CRC, fpa_pkg::D_CALMEM_CRC};
            d_q[k] = (k == fpa_pkg::D_SCLK_COUNT);
            a_msk[k] = k inside {fpa_pkg::A_OVERVOLT, fpa_pkg::A_CONV_SHORT, fpa_pkg::A_IOUT_OPEN,
                fpa_pkg::A_VOUT_SHORT, fpa_pkg::A_CONV_TEMP, fpa_pkg::A_MAIN_TEMP};
            a_alw[k] = k inside {fpa_pkg::A_CONV_POWER, fpa_pkg::A_REF_OUTPUT, fpa_pkg::A_REF_INPUT,
                fpa_pkg::A_INT_SUPPLY, fpa_pkg::A_LDO_CMP};
        end
        repeat (6) @(negedge clk);
        check_all(16'h0000, 16'h0000, 1'b0);
        rst = 1'b0;
        for (int f = 0; f < 2; f++)
        begin
            for (int i = 0; i < 16; i++) probe(1'b0, i, f[0]);
            for (int i = 0; i < 12; i++) probe(1'b1, i, f[0]);
        end
        dig_mask = 16'h0000;
        ana_mask = 12'h000;
        quiet = 1'b0;
        for (int s = 0; s < 4; s++) temp_case(s);
        // count error ignores every mask; quiet enable spares unmasked sources
        dig_mask = 16'hffff;
        dig_fault = fpa_pkg::DIG_QUIETABLE;
        @(negedge clk);
        check_all(fpa_pkg::DIG_QUIETABLE, 16'h0000, 1'b1);
        quiet = 1'b1;
        dig_mask = 16'h0000;
        dig_fault = 16'h0001;
        dig_update = 16'hffff;
        @(negedge clk);
        check_all(16'h0001, 16'h0000, 1'b1);
        quiet = 1'b0;
        dig_fault = 16'h0000;
        @(negedge clk);
        dig_update = 16'h0000;
        check_all(16'h0000, 16'h0000, 1'b0);
        // frozen by clock enable, then masked source recorded, then unmasked
        ce = 1'b0;
        dig_mask = 16'hffff;
        dig_fault = 16'h0001;
        @(negedge clk);
        check_all(16'h0000, 16'h0000, 1'b0);
        ce = 1'b1;
        @(negedge clk);
        check_all(16'h0001, 16'h0000, 1'b0);
        dig_mask = 16'h0000;
        @(negedge clk);
        check_all(16'h0001, 16'h0000, 1'b1);
        // reset in mid-run, then another device pulls the shared line
        dig_fault = 16'h0000;
        rst = 1'b1;
        @(negedge clk);
        check_all(16'h0000, 16'h0000, 1'b0);
        rst = 1'b0;
        other_pull_n = 1'b0;
        @(negedge clk);
        check_bit("shared_line", 1'b0, line);
        check_bit("mirror_other", 1'b0, mirror);
        other_pull_n = 1'b1;
        give_verdict();
    end

    initial
    begin
        #100000;
        mismatches++;
        give_verdict();
    end
endmodule : fpa_top_bench
